//--- hdl/ext_regs_pkg.sv
package ext_regs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_PCS_CTL = 5'h10;
  localparam logic [4:0] IDX_INT_MASK = 5'h1C;
  localparam logic [4:0] IDX_INT_STATUS = 5'h1D;
  localparam logic [4:0] IDX_RING_CTL = 5'h1E;
  localparam logic [4:0] IDX_PAGE_SEL = 5'h1F;
  localparam logic [4:0] IDX_EXT_FIRST = 5'h10;
  localparam logic [4:0] IDX_EXT_LAST = 5'h1E;

  // Page select values
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_EXT2 = 16'h0002;
  localparam logic [15:0] PAGE_EXT3 = 16'h0003;

  // Interrupt status and mask positions
  localparam int INT_MEM_RING_BIT = 10;
  localparam int INT_SWITCH_DONE_BIT = 4;
  localparam int INT_EEE_MSB = 3;
  localparam logic [15:0] INT_VALID_MASK = 16'h041F;

  // Ring control positions
  localparam int RING_STARTUP_BIT = 15;
  localparam int RING_ADVERTISE_BIT = 14;
  localparam int RING_PARTNER_ADV_BIT = 13;
  localparam int RING_FORCE_BIT = 12;
  localparam int RING_ROLE_LSB = 4;
  localparam int RING_START_BIT = 0;

  // Serializer PCS control positions
  localparam int PCS_DISABLE_BIT = 15;
  localparam int PCS_RESTART_BIT = 14;
  localparam int PCS_PARALLEL_DETECT_BIT = 13;

  // Reset value and timing-role codes
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [1:0] ROLE_SLAVE_CODE = 2'h0;
  localparam logic [1:0] ROLE_S2M_CODE = 2'h2;
  localparam logic [1:0] ROLE_MASTER_CODE = 2'h3;
  localparam logic [1:0] ROLE_M2S_CODE = 2'h1;

  // Cycles a timing-role switchover takes to settle
  localparam int SWITCHOVER_CYCLES = 16;

  typedef enum logic [1:0] {
    ROLE_SLAVE,
    ROLE_SLAVE_TO_MASTER,
    ROLE_MASTER,
    ROLE_MASTER_TO_SLAVE
  } timing_role_t;

  typedef struct packed {
    logic startup_en;
    logic advertise;
    logic force_en;
  } ring_ctl_t;

  typedef struct packed {
    logic if_disable;
    logic if_restart;
    logic parallel_detect;
  } pcs_ctl_t;

endpackage

//--- hdl/ext_status_ring_page_regs.sv
// Notes on behaviour
// - Status bit 10 flags pending memory-integrity ring interrupt, clears when read.
// - Status bit 4 flags pending switchover-complete interrupt, clears when read.
// - Status bits 3:0 flag EEE events, each clears when read.
// - Ring bit 15 is sticky startup enable, the master timing-role enable, reset 0.
// - Ring bit 14 is sticky; advertises ring capability in autonegotiation.
// - Ring bit 13 reads whether link partner advertised ring capability.
// - Ring bit 12 is sticky; forces ring resiliency regardless of autonegotiation.
// - Ring bits 5:4 give role: 00 slave, 10 to master, 11 master, 01 to slave.
// - Steady roles follow autonegotiated master/slave result at link-up.
// - Writing 1 to ring bit 0 starts switchover, only when none in progress.
// - Writing 0x0003 to index 31 selects the page-3 register set.
// - With page 3 selected, indices 16-30 reach page-3 registers.
// - Indices 0-15 always reach standard registers.
// - Writing 0x0000 to index 31 restores main mapping of indices 16-30.
// - PCS bit 15 disables MAC interface while media link is down.
// - PCS bit 14 restarts MAC interface on every media link change.
// - PCS bit 13 enables parallel detection in MAC autonegotiation.
// - Mask register has sticky enable bit per status bit, same position.
`timescale 1ns/100ps
module ext_status_ring_page_regs
  import ext_regs_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int SWITCH_CYCLES = SWITCHOVER_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic soft_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mem_ring_event,
  input wire logic [3:0] eee_events,
  input wire logic link_partner_ring_adv,
  input wire logic an_master_resolved,
  input wire logic copper_link_up,
  input wire logic media_link_up,
  output logic ring_startup_en,
  output logic ring_advertise,
  output logic ring_force,
  output logic [1:0] timing_role,
  output logic ring_switchover_active,
  output logic mac_if_disable,
  output logic mac_if_restart,
  output logic parallel_detect_en,
  output logic [15:0] ext_int_mask
);

  localparam int CNT_W = $clog2(SWITCH_CYCLES + 1);
  localparam logic [CNT_W-1:0] SWITCH_LAST = CNT_W'(SWITCH_CYCLES - 1);

  logic [15:0] page_reg;
  logic [15:0] std_reg [0:30];
  logic [15:0] int_status_reg;
  logic [15:0] int_mask_reg;
  ring_ctl_t ring_reg;
  pcs_ctl_t pcs_reg;
  logic start_reg;
  logic partner_adv_reg;
  timing_role_t role_reg;
  logic [CNT_W-1:0] switch_cnt_reg;
  logic copper_prev_reg;
  logic media_prev_reg;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  logic [4:0] idx;
  logic mapped;
  logic in_ext;
  logic hit_std;
  logic hit_page;
  logic hit_mask;
  logic hit_status;
  logic hit_ring;
  logic hit_pcs;
  logic access_wait;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic [15:0] rd_word;
  logic [1:0] role_code;
  logic role_steady;
  logic switch_done;
  logic [15:0] int_events;

  // Two-cycle access: first access cycle latches read data, second completes
  assign access_wait = psel && penable && !pready_reg;
  assign access_done = psel && penable && pready_reg;
  assign idx = paddr[6:2];
  assign mapped = (paddr[ADDR_W-1:7] == '0);
  assign wr_done = access_done && pwrite && mapped && !pslverr_reg;
  assign rd_done = access_done && !pwrite && mapped && !pslverr_reg;

  assign in_ext = (idx >= IDX_EXT_FIRST) && (idx <= IDX_EXT_LAST);
  assign hit_std = (idx != IDX_PAGE_SEL) && (!in_ext || page_reg == PAGE_MAIN);
  assign hit_page = (idx == IDX_PAGE_SEL);
  assign hit_mask = in_ext && page_reg == PAGE_EXT2 && idx == IDX_INT_MASK;
  assign hit_status = in_ext && page_reg == PAGE_EXT2 && idx == IDX_INT_STATUS;
  assign hit_ring = in_ext && page_reg == PAGE_EXT2 && idx == IDX_RING_CTL;
  assign hit_pcs = in_ext && page_reg == PAGE_EXT3 && idx == IDX_PCS_CTL;

  always_comb begin
    role_code = ROLE_SLAVE_CODE;
    unique case (role_reg)
      ROLE_SLAVE: role_code = ROLE_SLAVE_CODE;
      ROLE_SLAVE_TO_MASTER: role_code = ROLE_S2M_CODE;
      ROLE_MASTER: role_code = ROLE_MASTER_CODE;
      ROLE_MASTER_TO_SLAVE: role_code = ROLE_M2S_CODE;
    endcase
  end

  assign role_steady = (role_reg == ROLE_SLAVE) || (role_reg == ROLE_MASTER);
  assign switch_done = !role_steady && (switch_cnt_reg == SWITCH_LAST);

  always_comb begin
    rd_word = RESET_WORD;
    if (hit_page) begin
      rd_word = page_reg;
    end else if (hit_std) begin
      rd_word = std_reg[idx];
    end else if (hit_mask) begin
      rd_word = int_mask_reg & INT_VALID_MASK;
    end else if (hit_status) begin
      rd_word = int_status_reg & INT_VALID_MASK;
    end else if (hit_ring) begin
      rd_word[RING_STARTUP_BIT] = ring_reg.startup_en;
      rd_word[RING_ADVERTISE_BIT] = ring_reg.advertise;
      rd_word[RING_PARTNER_ADV_BIT] = partner_adv_reg;
      rd_word[RING_FORCE_BIT] = ring_reg.force_en;
      rd_word[RING_ROLE_LSB +: 2] = role_code;
      rd_word[RING_START_BIT] = start_reg;
    end else if (hit_pcs) begin
      rd_word[PCS_DISABLE_BIT] = pcs_reg.if_disable;
      rd_word[PCS_RESTART_BIT] = pcs_reg.if_restart;
      rd_word[PCS_PARALLEL_DETECT_BIT] = pcs_reg.parallel_detect;
    end
  end

  // Bus answer; out-of-window addresses error and read zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= access_wait;
      if (access_wait) begin
        prdata_reg <= mapped && !pwrite ? {16'h0000, rd_word} : 32'h00000000;
        pslverr_reg <= !mapped;
      end else if (access_done) begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // Page select is not sticky, so a soft reset returns to main mapping
  always_ff @(posedge clk) begin
    if (!resetn || soft_reset) begin
      page_reg <= PAGE_MAIN;
    end else if (wr_done && hit_page) begin
      page_reg <= pwdata[15:0];
    end
  end

  // Stand-in storage for the standard register space
  always_ff @(posedge clk) begin
    if (!resetn || soft_reset) begin
      for (int i = 0; i < 31; i++) begin
        std_reg[i] <= RESET_WORD;
      end
    end else if (wr_done && hit_std) begin
      std_reg[idx] <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      int_mask_reg <= RESET_WORD;
    end else if (wr_done && hit_mask) begin
      int_mask_reg <= pwdata[15:0] & INT_VALID_MASK;
    end
  end

  always_comb begin
    int_events = RESET_WORD;
    int_events[INT_MEM_RING_BIT] = mem_ring_event;
    int_events[INT_SWITCH_DONE_BIT] = switch_done;
    int_events[INT_EEE_MSB:0] = eee_events;
  end

  // clear only what was returned; a new event wins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      int_status_reg <= RESET_WORD;
    end else if (rd_done && hit_status) begin
      int_status_reg <= ((int_status_reg & ~prdata_reg[15:0]) | int_events) & INT_VALID_MASK;
    end else begin
      int_status_reg <= (int_status_reg | int_events) & INT_VALID_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ring_reg <= '0;
    end else if (wr_done && hit_ring) begin
      ring_reg.startup_en <= pwdata[RING_STARTUP_BIT];
      ring_reg.advertise <= pwdata[RING_ADVERTISE_BIT];
      ring_reg.force_en <= pwdata[RING_FORCE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      partner_adv_reg <= 1'b0;
    end else begin
      partner_adv_reg <= link_partner_ring_adv;
    end
  end

  // start accepted only from a steady role, then self-clears
  always_ff @(posedge clk) begin
    if (!resetn) begin
      start_reg <= 1'b0;
    end else if (wr_done && hit_ring && pwdata[RING_START_BIT] && role_steady && !start_reg) begin
      start_reg <= 1'b1;
    end else begin
      start_reg <= 1'b0;
    end
  end

  // Starts low: a link already up after reset counts as a fresh link-up
  always_ff @(posedge clk) begin
    if (!resetn) begin
      copper_prev_reg <= 1'b0;
    end else begin
      copper_prev_reg <= copper_link_up;
    end
  end

  // Link-up result overrides a switchover that is still settling
  always_ff @(posedge clk) begin
    if (!resetn) begin
      role_reg <= ROLE_SLAVE;
      switch_cnt_reg <= '0;
    end else if (copper_link_up && !copper_prev_reg) begin
      role_reg <= an_master_resolved ? ROLE_MASTER : ROLE_SLAVE;
      switch_cnt_reg <= '0;
    end else begin
      unique case (role_reg)
        ROLE_SLAVE: begin
          switch_cnt_reg <= '0;
          if (start_reg) begin
            role_reg <= ROLE_SLAVE_TO_MASTER;
          end
        end
        ROLE_MASTER: begin
          switch_cnt_reg <= '0;
          if (start_reg) begin
            role_reg <= ROLE_MASTER_TO_SLAVE;
          end
        end
        ROLE_SLAVE_TO_MASTER: begin
          switch_cnt_reg <= switch_cnt_reg + CNT_W'(1);
          if (switch_done) begin
            role_reg <= ROLE_MASTER;
          end
        end
        ROLE_MASTER_TO_SLAVE: begin
          switch_cnt_reg <= switch_cnt_reg + CNT_W'(1);
          if (switch_done) begin
            role_reg <= ROLE_SLAVE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pcs_reg <= '0;
    end else if (wr_done && hit_pcs) begin
      pcs_reg.if_disable <= pwdata[PCS_DISABLE_BIT];
      pcs_reg.if_restart <= pwdata[PCS_RESTART_BIT];
      pcs_reg.parallel_detect <= pwdata[PCS_PARALLEL_DETECT_BIT];
    end
  end

  // Previous media level for change detection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      media_prev_reg <= 1'b0;
    end else begin
      media_prev_reg <= media_link_up;
    end
  end

  // MAC interface controls, each a flop so outputs stay glitch free
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mac_if_disable <= 1'b0;
      mac_if_restart <= 1'b0;
      parallel_detect_en <= 1'b0;
    end else begin
      mac_if_disable <= pcs_reg.if_disable && !media_link_up;
      mac_if_restart <= pcs_reg.if_restart && (media_link_up != media_prev_reg);
      parallel_detect_en <= pcs_reg.parallel_detect;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ring_startup_en <= 1'b0;
      ring_advertise <= 1'b0;
      ring_force <= 1'b0;
    end else begin
      ring_startup_en <= ring_reg.startup_en;
      ring_advertise <= ring_reg.advertise;
      ring_force <= ring_reg.force_en;
    end
  end

  // code and flag from one state, so they never disagree
  always_ff @(posedge clk) begin
    if (!resetn) begin
      timing_role <= ROLE_SLAVE_CODE;
      ring_switchover_active <= 1'b0;
    end else begin
      timing_role <= role_code;
      ring_switchover_active <= !role_steady;
    end
  end

  // mask copy for the interrupt combiner outside
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ext_int_mask <= RESET_WORD;
    end else begin
      ext_int_mask <= int_mask_reg;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule

//--- sim/ext_status_ring_page_regs_props.sv
`timescale 1ns/100ps
module ext_regs_props #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic media_link_up,
  input wire logic ring_startup_en,
  input wire logic ring_advertise,
  input wire logic ring_force,
  input wire logic [1:0] timing_role,
  input wire logic ring_switchover_active,
  input wire logic mac_if_disable,
  input wire logic mac_if_restart,
  input wire logic parallel_detect_en,
  input wire logic [15:0] ext_int_mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic wr_done;
  logic far;
  assign wr_done = pready && pwrite;
  assign far = paddr[ADDR_W-1:7] != '0;
  AST_ACCESS_PHASE: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside access phase");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_UNMAPPED: assert property (pready && far |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  AST_ERR_MAPPED: assert property (pready && !far |-> !pslverr)
    else $error("mapped access refused");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  AST_DISABLE_LINK: assert property (mac_if_disable |-> $past(!media_link_up))
    else $error("interface disabled with media up");
  AST_RESTART_CAUSE: assert property (mac_if_restart |->
    ($past(media_link_up) != $past(media_link_up, 2)) || ($past(media_link_up, 2) != $past(media_link_up, 3)))
    else $error("restart without media change");
  AST_CTL_BY_WRITE: assert property ($changed({ring_startup_en, ring_advertise, ring_force, parallel_detect_en}) |->
    $past(wr_done) || $past(wr_done, 2))
    else $error("sticky control moved without write");
  AST_MASK_BY_WRITE: assert property ($changed(ext_int_mask) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("mask moved without write");
  AST_ROLE_ACTIVE: assert property (ring_switchover_active == (timing_role[1] ^ timing_role[0]))
    else $error("switchover flag disagrees with role code");
  cover property ($rose(ring_switchover_active));
  cover property (pready && pslverr);
  cover property (mac_if_restart);
  cover property ($rose(parallel_detect_en));
endmodule

bind ext_status_ring_page_regs ext_regs_props #(.ADDR_W(ADDR_W)) i_props (.clk, .resetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .media_link_up, .ring_startup_en, .ring_advertise, .ring_force,
  .timing_role, .ring_switchover_active,
  .mac_if_disable, .mac_if_restart, .parallel_detect_en, .ext_int_mask);

//--- sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  import ext_regs_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic soft_reset = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic mem_ring_event = 1'b0;
  logic [3:0] eee_events = 4'h0;
  logic link_partner_ring_adv = 1'b0;
  logic an_master_resolved = 1'b0;
  logic copper_link_up = 1'b0;
  logic media_link_up = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, ring_startup_en, ring_advertise, ring_force, ring_switchover_active;
  logic mac_if_disable, mac_if_restart, parallel_detect_en;
  logic [1:0] timing_role;
  logic [15:0] ext_int_mask;
  logic [15:0] rd;
  logic er;
  int err_total = 0;
  int check_count = 0;

  ext_status_ring_page_regs #(.ADDR_W(12), .SWITCH_CYCLES(8)) i_dut (
    .clk(clk),
    .resetn(resetn),
    .soft_reset(soft_reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .mem_ring_event(mem_ring_event),
    .eee_events(eee_events),
    .link_partner_ring_adv(link_partner_ring_adv),
    .an_master_resolved(an_master_resolved),
    .copper_link_up(copper_link_up),
    .media_link_up(media_link_up),
    .ring_startup_en(ring_startup_en),
    .ring_advertise(ring_advertise),
    .ring_force(ring_force),
    .timing_role(timing_role),
    .ring_switchover_active(ring_switchover_active),
    .mac_if_disable(mac_if_disable),
    .mac_if_restart(mac_if_restart),
    .parallel_detect_en(parallel_detect_en),
    .ext_int_mask(ext_int_mask)
  );

  always #2.5 clk = ~clk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Reads after the edge see pre-edge values, i.e. what the edge sampled
  task apb(input logic w, input logic [4:0] idx, input logic [15:0] wd, input logic hi);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {hi, 4'h0, idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED %0t bus timeout", $time);
    end
    rd = prdata[15:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [4:0] idx, input logic [15:0] d);
    apb(1'b1, idx, d, 1'b0);
  endtask

  task rdx(input logic [4:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0000, 1'b0);
    chk(rd, exp);
  endtask

  task wait_idle;
    int n;
    n = 0;
    while (ring_switchover_active !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(n < 100, 1'b1);
    cyc(3);
  endtask

  task t_ring;
    wr(IDX_PAGE_SEL, PAGE_EXT2);
    rdx(IDX_RING_CTL, 16'h0000);
    wr(IDX_RING_CTL, 16'hF00E);
    rdx(IDX_RING_CTL, 16'hD000);
    link_partner_ring_adv <= 1'b1;
    cyc(2);
    rdx(IDX_RING_CTL, 16'hF000);
    chk({ring_startup_en, ring_advertise, ring_force}, 3'b111);
    wr(IDX_INT_MASK, 16'h041F);
    cyc(2);
    chk(ext_int_mask, 16'h041F);
  endtask

  task t_status;
    mem_ring_event <= 1'b1;
    eee_events <= 4'hF;
    @(posedge clk);
    mem_ring_event <= 1'b0;
    eee_events <= 4'h0;
    rdx(IDX_INT_STATUS, 16'h040F);
    rdx(IDX_INT_STATUS, 16'h0000);
    eee_events <= 4'h1;
    @(posedge clk);
    eee_events <= 4'h0;
    // Same bit fires again exactly at the clearing edge of the read
    fork
      rdx(IDX_INT_STATUS, 16'h0001);
      begin
        cyc(2);
        eee_events <= 4'h1;
        @(posedge clk);
        eee_events <= 4'h0;
      end
    join
    rdx(IDX_INT_STATUS, 16'h0001);
    rdx(IDX_INT_STATUS, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      eee_events <= 4'h1 << i;
      @(posedge clk);
      eee_events <= 4'h0;
      rdx(IDX_INT_STATUS, 16'h0001 << i);
    end
    wr(IDX_INT_STATUS, 16'hFFFF);
    rdx(IDX_INT_STATUS, 16'h0000);
  endtask

  task t_switch;
    an_master_resolved <= 1'b1;
    copper_link_up <= 1'b1;
    cyc(3);
    chk(timing_role, ROLE_MASTER_CODE);
    wr(IDX_RING_CTL, 16'hF001);
    // Second start lands mid-switchover and must be dropped
    wr(IDX_RING_CTL, 16'hF001);
    chk({ring_switchover_active, timing_role}, {1'b1, ROLE_M2S_CODE});
    wait_idle();
    chk(timing_role, ROLE_SLAVE_CODE);
    rdx(IDX_INT_STATUS, 16'h0010);
    rdx(IDX_RING_CTL, 16'hF000);
    wr(IDX_RING_CTL, 16'hF001);
    cyc(2);
    chk(timing_role, ROLE_S2M_CODE);
    wait_idle();
    rdx(IDX_RING_CTL, 16'hF030);
  endtask

  task t_page;
    int seen;
    seen = 0;
    wr(IDX_PAGE_SEL, PAGE_MAIN);
    wr(5'h05, 16'h00A5);
    wr(IDX_PCS_CTL, 16'h1234);
    wr(IDX_PAGE_SEL, PAGE_EXT3);
    wr(IDX_PCS_CTL, 16'hE000);
    rdx(IDX_PCS_CTL, 16'hE000);
    rdx(5'h05, 16'h00A5);
    chk({mac_if_disable, parallel_detect_en}, 2'b11);
    media_link_up <= 1'b1;
    repeat (6) begin
      @(posedge clk);
      seen += int'(mac_if_restart === 1'b1);
    end
    chk(seen, 1);
    chk(mac_if_disable, 1'b0);
    wr(IDX_PAGE_SEL, PAGE_MAIN);
    rdx(IDX_PCS_CTL, 16'h1234);
    apb(1'b0, IDX_RING_CTL, 16'h0000, 1'b1);
    chk({er, rd}, {1'b1, 16'h0000});
  endtask

  task t_resets;
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    @(posedge clk);
    rdx(5'h05, 16'h0000);
    rdx(IDX_PCS_CTL, 16'h0000);
    wr(IDX_PAGE_SEL, PAGE_EXT3);
    rdx(IDX_PCS_CTL, 16'hE000);
    // A hardware reset takes the copper link down with it
    resetn <= 1'b0;
    copper_link_up <= 1'b0;
    cyc(3);
    resetn <= 1'b1;
    @(posedge clk);
    wr(IDX_PAGE_SEL, PAGE_EXT2);
    rdx(IDX_RING_CTL, 16'h2000);
  endtask

  task end_of_test;
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_ring();
    t_status();
    t_switch();
    t_page();
    t_resets();
    end_of_test();
  end
endmodule
